// *** wwd_top.v ***
// Window watchdog with AXI4-Lite register slave and interrupt.
// Assumes core instruction strobes on sys_clk; wake-up oscillator arrives as an asynchronous pin.
`timescale 1ns/1ns
`include "wwd_defs.vh"
module wwd_top
(
    sys_clk,
    rst,
    guard_off_instruction,
    guard_on_instruction,
    service_instruction,
    wakeup_osc_clk,
    reset_req,
    irq,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready
);
    input  wire        sys_clk;
    input  wire        rst;
    input  wire        guard_off_instruction;
    input  wire        guard_on_instruction;
    input  wire        service_instruction;
    input  wire        wakeup_osc_clk;
    output wire        reset_req;
    output wire        irq;
    input  wire [7:0]  s_axi_awaddr;
    input  wire        s_axi_awvalid;
    output wire        s_axi_awready;
    input  wire [31:0] s_axi_wdata;
    input  wire [3:0]  s_axi_wstrb;
    input  wire        s_axi_wvalid;
    output wire        s_axi_wready;
    output wire [1:0]  s_axi_bresp;
    output wire        s_axi_bvalid;
    input  wire        s_axi_bready;
    input  wire [7:0]  s_axi_araddr;
    input  wire        s_axi_arvalid;
    output wire        s_axi_arready;
    output wire [31:0] s_axi_rdata;
    output wire [1:0]  s_axi_rresp;
    output wire        s_axi_rvalid;
    input  wire        s_axi_rready;

    localparam [31:0]  DFLT_RELOAD32 = `WWD_DFLT_RELOAD;
    localparam [15:0]  DFLT_RELOAD   = DFLT_RELOAD32[15:0];
    localparam [15:0]  CNT_MAX       = 16'hFFFF;

    // Byte-lane merge of a write into a register image
    function [31:0] lane_merge;
        input [31:0] old_val;
        input [31:0] new_val;
        input [3:0]  strb;
        integer i;
        begin
            for (i = 0; i < 4; i = i + 1)
                lane_merge[i*8 +: 8] = strb[i] ? new_val[i*8 +: 8] : old_val[i*8 +: 8];
        end
    endfunction

    // Address decode shared by read and write paths
    function addr_hit;
        input [7:0] addr;
        begin
            addr_hit = (addr == `WWD_OFS_CTRL)   || (addr == `WWD_OFS_RELOAD) ||
                       (addr == `WWD_OFS_WINDOW) || (addr == `WWD_OFS_COUNT)  ||
                       (addr == `WWD_OFS_STATUS) || (addr == `WWD_OFS_MASK);
        end
    endfunction

    // Configuration and state
    reg                   src_wu_r;
    reg                   pre_fast_r;
    reg  [15:0]           reload_value_field_r;
    reg  [15:0]           window_r;
    reg  [15:0]           cnt_r;
    reg                   run_r;
    reg  [`WWD_ST_W-1:0]  status_r;
    reg  [`WWD_ST_W-1:0]  mask_r;
    reg                   reset_req_r;
    reg                   irq_r;

    // Bus slave state
    reg                   awready_r;
    reg                   wready_r;
    reg                   aw_full_r;
    reg                   w_full_r;
    reg  [7:0]            awaddr_r;
    reg  [31:0]           wdata_r;
    reg  [3:0]            wstrb_r;
    reg                   bvalid_r;
    reg  [1:0]            bresp_r;
    reg                   arready_r;
    reg                   rvalid_r;
    reg  [31:0]           rdata_r;
    reg  [1:0]            rresp_r;

    wire                  wu_edge;
    wire                  pre_tick;

    // Write channel bookkeeping; address and data accepted in either order
    wire                  aw_take = s_axi_awvalid & awready_r;
    wire                  w_take  = s_axi_wvalid & wready_r;
    wire                  aw_have = aw_full_r | aw_take;
    wire                  w_have  = w_full_r | w_take;
    wire                  do_wr   = aw_have & w_have & ~bvalid_r;
    wire [7:0]            wr_addr = aw_full_r ? awaddr_r : s_axi_awaddr;
    wire [31:0]           wr_data = w_full_r ? wdata_r : s_axi_wdata;
    wire [3:0]            wr_strb = w_full_r ? wstrb_r : s_axi_wstrb;
    wire                  bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
    wire                  aw_full_nxt = aw_have & ~do_wr;
    wire                  w_full_nxt  = w_have & ~do_wr;
    wire                  ar_take = s_axi_arvalid & arready_r;
    wire                  rvalid_nxt = ar_take | (rvalid_r & ~s_axi_rready);

    wire                  wr_ctrl   = do_wr & (wr_addr == `WWD_OFS_CTRL);
    wire                  wr_reload = do_wr & (wr_addr == `WWD_OFS_RELOAD);
    wire                  wr_window = do_wr & (wr_addr == `WWD_OFS_WINDOW);
    wire                  wr_status = do_wr & (wr_addr == `WWD_OFS_STATUS);
    wire                  wr_mask   = do_wr & (wr_addr == `WWD_OFS_MASK);

    wire [31:0]           ctrl_img = {30'h0000_0000, pre_fast_r, src_wu_r};
    wire [31:0]           ctrl_new = lane_merge(ctrl_img, wr_data, wr_strb);
    wire [31:0]           rel_new  = lane_merge({16'h0000, reload_value_field_r}, wr_data, wr_strb);
    wire [31:0]           win_new  = lane_merge({16'h0000, window_r}, wr_data, wr_strb);
    wire [31:0]           mask_new = lane_merge({29'h0000_0000, mask_r}, wr_data, wr_strb);
    wire [`WWD_ST_W-1:0]  st_clr   = wr_status & wr_strb[0] ? wr_data[`WWD_ST_W-1:0] : {`WWD_ST_W{1'b0}};

    // Watchdog events
    wire                  early_svc = service_instruction & (cnt_r < window_r); // RL4 RL9
    wire                  ok_svc    = service_instruction & ~early_svc;
    wire                  ovf       = run_r & pre_tick & (cnt_r == CNT_MAX); // RL3
    wire [`WWD_ST_W-1:0]  events;
    wire [`WWD_ST_W-1:0]  status_nxt;

    assign events[`WWD_ST_OVF_BIT]   = ovf;
    assign events[`WWD_ST_EARLY_BIT] = early_svc;
    assign events[`WWD_ST_SVC_BIT]   = ok_svc;
    // New events win over a simultaneous clear
    assign status_nxt = (status_r & ~st_clr) | events;

    wwd_sync u_wu_sync
    (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .async_in   (wakeup_osc_clk),
        .rise_pulse (wu_edge)
    );

    // Divider is restarted by a service so every interval starts on a full tick
    wwd_prescale #(
        .SLOW (`WWD_PRE_SLOW),
        .FAST (`WWD_PRE_FAST),
        .W    (14)
    ) u_prescale
    (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .clear    (service_instruction),
        .tick_in  (run_r & (src_wu_r ? wu_edge : 1'b1)), // RL6 RL2
        .fast_sel (pre_fast_r),
        .tick_out (pre_tick)
    );

    // Counter, run state and reset request
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r       <= DFLT_RELOAD; // RL8
            run_r       <= 1'b1; // RL1
            reset_req_r <= 1'b0;
        end
        else
        begin
            // Enable takes precedence if both strobes arrive together
            if (guard_on_instruction)
                run_r <= 1'b1; // RL2
            else if (guard_off_instruction)
                run_r <= 1'b0; // RL2
            if (service_instruction)
                cnt_r <= reload_value_field_r; // RL7 RL9
            else if (ovf)
                cnt_r <= reload_value_field_r;
            else if (run_r & pre_tick)
                cnt_r <= cnt_r + 16'h0001; // RL5
            // Held until the reset logic resets this block
            if (ovf | early_svc)
                reset_req_r <= 1'b1; // RL3 RL4
        end
    end

    // Software-visible registers and interrupt
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            src_wu_r             <= `WWD_RST_SRC; // RL8
            pre_fast_r           <= `WWD_RST_PRE; // RL8
            reload_value_field_r <= DFLT_RELOAD; // RL8
            window_r             <= `WWD_RST_WINDOW;
            status_r             <= {`WWD_ST_W{1'b0}};
            mask_r               <= `WWD_RST_MASK;
            irq_r                <= 1'b0;
        end
        else
        begin
            if (wr_ctrl)
            begin
                src_wu_r   <= ctrl_new[`WWD_CTRL_SRC_BIT]; // RL6
                pre_fast_r <= ctrl_new[`WWD_CTRL_PRE_BIT]; // RL6
            end
            if (wr_reload)
                reload_value_field_r <= rel_new[15:0];
            if (wr_window)
                window_r <= win_new[15:0]; // RL9
            if (wr_mask)
                mask_r <= mask_new[`WWD_ST_W-1:0];
            status_r <= status_nxt;
            irq_r    <= |(status_nxt & mask_r);
        end
    end

    // AXI4-Lite write path
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h0000_0000;
            wstrb_r   <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `WWD_RESP_OKAY;
        end
        else
        begin
            if (aw_take)
                awaddr_r <= s_axi_awaddr;
            if (w_take)
            begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
            bvalid_r  <= bvalid_nxt;
            awready_r <= ~aw_full_nxt & ~bvalid_nxt;
            wready_r  <= ~w_full_nxt & ~bvalid_nxt;
            if (do_wr)
                bresp_r <= addr_hit(wr_addr) ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
        end
    end

    // AXI4-Lite read path
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h0000_0000;
            rresp_r   <= `WWD_RESP_OKAY;
        end
        else
        begin
            rvalid_r  <= rvalid_nxt;
            arready_r <= ~rvalid_nxt;
            if (ar_take)
            begin
                rresp_r <= addr_hit(s_axi_araddr) ? `WWD_RESP_OKAY : `WWD_RESP_SLVERR;
                case (s_axi_araddr)
                    `WWD_OFS_CTRL:   rdata_r <= ctrl_img;
                    `WWD_OFS_RELOAD: rdata_r <= {16'h0000, reload_value_field_r};
                    `WWD_OFS_WINDOW: rdata_r <= {16'h0000, window_r};
                    `WWD_OFS_COUNT:  rdata_r <= {15'h0000, run_r, cnt_r};
                    `WWD_OFS_STATUS: rdata_r <= {29'h0000_0000, status_r};
                    `WWD_OFS_MASK:   rdata_r <= {29'h0000_0000, mask_r};
                    default:         rdata_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign reset_req     = reset_req_r;
    assign irq           = irq_r;
    assign s_axi_awready = awready_r;
    assign s_axi_wready  = wready_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rvalid  = rvalid_r;
endmodule // wwd_top

// *** wwd_defs.vh ***
// Constants for the window watchdog: register map, field positions, reset values, timing.
// Assumes inclusion by bare name from the watchdog top-level source file.
// Overview of operation
// RL1: After reset the watchdog comes up running without any software action.
// RL2: The disable instruction stops counting and the enable instruction resumes it, at any time.
// RL3: If the counter overflows without a service, a reset request is raised.
// RL4: A service while the count is still below the window boundary is a fault and raises the reset request.
// RL5: The counter is 16 bits wide and counts upward toward overflow.
// RL6: The count clock is the system clock or the wake-up oscillator, divided by 16,384 or 256.
// RL7: Each accepted service loads the counter with the programmed reload value.
// RL8: The reset configuration gives a timeout of about 0.13 s from the 500 kHz wake-up oscillator.
// RL9: The window boundary is a programmable count; service is accepted at or past it and restarts the window.
`ifndef WWD_DEFS_VH
`define WWD_DEFS_VH

// Register byte offsets
`define WWD_OFS_CTRL        8'h00
`define WWD_OFS_RELOAD      8'h04
`define WWD_OFS_WINDOW      8'h08
`define WWD_OFS_COUNT       8'h0C
`define WWD_OFS_STATUS      8'h10
`define WWD_OFS_MASK        8'h14

// Control fields
`define WWD_CTRL_SRC_BIT    0
`define WWD_CTRL_PRE_BIT    1

// Status and mask fields
`define WWD_ST_OVF_BIT      0
`define WWD_ST_EARLY_BIT    1
`define WWD_ST_SVC_BIT      2
`define WWD_ST_W            3

// Count register fields
`define WWD_CNT_RUN_BIT     16

// Prescale factors
`define WWD_PRE_SLOW        16384
`define WWD_PRE_FAST        256

// Default timeout and the oscillator it is quoted for
`define WWD_DFLT_TIMEOUT_US 130000
`define WWD_WU_FREQ_KHZ     500
`define WWD_DFLT_TICKS      ((`WWD_DFLT_TIMEOUT_US * `WWD_WU_FREQ_KHZ / 1000 + `WWD_PRE_FAST / 2) / `WWD_PRE_FAST)
`define WWD_DFLT_RELOAD     (65536 - `WWD_DFLT_TICKS)

// Reset values
`define WWD_RST_SRC         1'b1
`define WWD_RST_PRE         1'b1
`define WWD_RST_WINDOW      16'h0000
`define WWD_RST_MASK        3'h0

// AXI responses
`define WWD_RESP_OKAY       2'b00
`define WWD_RESP_SLVERR     2'b10

`endif

// *** wwd_sync.v ***
// Three-stage synchroniser with an agreement filter and rising-edge pulse.
// Assumes an asynchronous input; output pulse is on the sys_clk domain.
`timescale 1ns/1ns
module wwd_sync
(
    sys_clk,
    rst,
    async_in,
    rise_pulse
);
    input  wire sys_clk;
    input  wire rst;
    input  wire async_in;
    output reg  rise_pulse;

    reg  [2:0] stage_r;
    reg        level_r;

    // Stage 0 feeds only stage 1; level moves once stages 1 and 2 agree
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            stage_r    <= 3'h0;
            level_r    <= 1'b0;
            rise_pulse <= 1'b0;
        end
        else
        begin
            stage_r    <= {stage_r[1:0], async_in};
            rise_pulse <= 1'b0;
            if (stage_r[1] == stage_r[2])
            begin
                level_r    <= stage_r[2];
                rise_pulse <= stage_r[2] & ~level_r;
            end
        end
    end
endmodule // wwd_sync

// *** wwd_prescale.v ***
// Selectable prescaler: one output tick per SLOW or FAST input ticks.
// Assumes tick_in is a one-cycle strobe on sys_clk; clear restarts the phase.
`timescale 1ns/1ns
module wwd_prescale
#(
    parameter SLOW = 16384,
    parameter FAST = 256,
    parameter W    = 14
)
(
    sys_clk,
    rst,
    clear,
    tick_in,
    fast_sel,
    tick_out
);
    input  wire sys_clk;
    input  wire rst;
    input  wire clear;
    input  wire tick_in;
    input  wire fast_sel;
    output reg  tick_out;

    localparam integer SLOW_LAST_I = SLOW - 1;
    localparam integer FAST_LAST_I = FAST - 1;
    localparam [W-1:0] SLOW_LAST   = SLOW_LAST_I[W-1:0];
    localparam [W-1:0] FAST_LAST   = FAST_LAST_I[W-1:0];

    reg  [W-1:0] div_r;
    wire [W-1:0] last = fast_sel ? FAST_LAST : SLOW_LAST;

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            div_r    <= {W{1'b0}};
            tick_out <= 1'b0;
        end
        else
        begin
            tick_out <= 1'b0;
            if (clear)
                div_r <= {W{1'b0}};
            else if (tick_in)
            begin
                // Reaching or passing the limit covers a factor change mid-count
                if (div_r >= last)
                begin
                    div_r    <= {W{1'b0}};
                    tick_out <= 1'b1; // RL6
                end
                else
                    div_r <= div_r + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // wwd_prescale

// *** wwd_osc_model.sv ***
// Wake-up oscillator model that drives the watchdog's count clock pin.
// Assumes nothing of the bench; it runs free from time zero.
`timescale 1ns/1ns
module wwd_osc_model
#(
    parameter int HALF_NS = 37
)
(
    output logic osc_clk
);
    // Off-grid half period, so edges drift against sys_clk
    initial
    begin
        osc_clk = 1'b0;
        forever #(HALF_NS) osc_clk = ~osc_clk;
    end
endmodule // wwd_osc_model

// *** wwd_top_assertions.sv ***
// Port checker for the window watchdog top level.
// Assumes binding onto wwd_top; sees only its ports.
`timescale 1ns/1ns
module wwd_chk
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        reset_req,
    input wire logic        irq,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_req_sticky: assert property (reset_req |=> reset_req)
        else $error("reset request dropped");
    chk_quiet_start: assert property ($fell(rst) |-> (!reset_req && !irq)[*4])
        else $error("fault raised right after reset");
    chk_wr_answer: assert property (s_wr_taken |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response missing");
    chk_b_stand: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    chk_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    chk_r_stand: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while busy");
    chk_rd_unmapped: assert property (s_rd_taken ##0 s_axi_araddr > 8'h14 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 0)
        else $error("unmapped read not refused");
endmodule // wwd_chk
bind wwd_top wwd_chk u_chk (.sys_clk(sys_clk), .rst(rst), .reset_req(reset_req), .irq(irq),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** window_watchdog_timer_test.sv ***
// Self-checking bench for the window watchdog.
// Assumes wwd_top, its checker and the oscillator model compiled before it.
`timescale 1ns/1ns
module window_watchdog_timer_test;
    logic        sys_clk, rst, off_i, on_i, svc_i;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, seed, rd, r;
    logic        awvalid, wvalid, bready, arvalid, rready;
    logic [1:0]  rs;
    wire         osc_clk, reset_req, irq, awready, wready, bvalid, arready, rvalid;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    int          errors, n_tests, i, k, u, lo;

    wwd_osc_model u_osc (.osc_clk(osc_clk));
    wwd_top uut (.sys_clk(sys_clk), .rst(rst), .guard_off_instruction(off_i), .guard_on_instruction(on_i),
        .service_instruction(svc_i), .wakeup_osc_clk(osc_clk), .reset_req(reset_req), .irq(irq),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] xrand();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Default reload: 0.13 s of 500 kHz ticks through /256
    function automatic logic [31:0] exp_rst(input int idx);
        case (idx)
            0: return 32'h0000_0003;
            1: return 32'h0001_0000 - (130000 * 500 / 1000 + 128) / 256;
            3: return 32'h0001_0000;
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask

    task automatic give_up(input string nm);
        check(nm, 1, 0);
        test_done();
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        // Either channel may be taken first
        for (n = 0; n < 64; n++)
        begin
            @(posedge sys_clk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
            if ((awready || !awvalid) && (wready || !wvalid))
                break;
        end
        bready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (!bvalid && n < 128);
        resp = bresp;
        bready <= 1'b0;
        if (n >= 128)
            give_up("write_handshake");
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (!arready && n < 64);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (!rvalid && n < 128);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 128)
            give_up("read_handshake");
    endtask

    // Holding the strobe for n cycles issues n back-to-back instructions
    task automatic pulse(input int which, input int n);
        if (which == 0)
            off_i <= 1'b1;
        else if (which == 1)
            on_i <= 1'b1;
        else
            svc_i <= 1'b1;
        repeat (n) @(posedge sys_clk);
        off_i <= 1'b0;
        on_i <= 1'b0;
        svc_i <= 1'b0;
    endtask

    task automatic do_reset();
        rst <= 1'b1;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
    endtask

    initial
    begin
        {rst, off_i, on_i, svc_i, awvalid, wvalid, bready, arvalid, rready} = 9'h1_00;
        {awaddr, araddr, wdata} = '0;
        seed = 32'h0000_dc75;
        errors = 0;
        n_tests = 0;
        do_reset();
        for (i = 0; i < 7; i++)
        begin
            axr(8'(4 * i), rd, rs);
            check("reset_val", exp_rst(i), (i == 3) ? rd & 32'h0001_0000 : rd);
            check("read_resp", (i == 6) ? 2 : 0, rs);
        end
        axw(8'h18, 32'h0000_0001, rs);
        check("unmapped_wr", 2, rs);
        $display("test reset_values done");

        axw(8'h00, 32'h0000_0002, rs);
        pulse(0, 1);
        axr(8'h0C, rd, rs);
        repeat (600) @(posedge sys_clk);
        axr(8'h0C, r, rs);
        check("halted_count", rd, r);
        pulse(1, 1);
        repeat (600) @(posedge sys_clk);
        axr(8'h0C, rd, rs);
        check("counts_up", 1, rd[16] && (rd[15:0] - r[15:0] == 2 || rd[15:0] - r[15:0] == 3));
        $display("test disable_enable done");

        do_reset();
        r = 32'h0000_8000 | (xrand() & 32'h0000_3fff);
        axw(8'h00, 32'h0000_0002, rs);
        axw(8'h04, r, rs);
        axw(8'h08, r, rs);
        axw(8'h14, 32'h0000_0006, rs);
        pulse(2, 2);
        axr(8'h0C, rd, rs);
        check("reloaded", r | 32'h0001_0000, rd);
        check("boundary_ok", 0, reset_req);
        axr(8'h10, rd, rs);
        check("svc_status", 4, rd);
        check("irq_svc", 1, irq);
        axw(8'h10, 32'h0000_0004, rs);
        @(posedge sys_clk);
        check("irq_cleared", 0, irq);
        axw(8'h08, r + 1, rs);
        pulse(2, 1);
        @(posedge sys_clk);
        check("early_req", 1, reset_req);
        axr(8'h10, rd, rs);
        check("early_status", 2, rd);
        check("irq_early", 1, irq);
        $display("test window_service done");

        // Sys clock and oscillator through /256, then sys clock through /16384 from a full reload
        for (i = 0; i < 3; i++)
        begin
            do_reset();
            axw(8'h00, (i == 2) ? 32'h0000_0000 : 32'h0000_0002 | i, rs);
            axw(8'h04, (i == 2) ? 32'h0000_ffff : 32'h0000_fffe, rs);
            pulse(2, 1);
            u = (i == 2) ? 24 : (i ? 8 : 1);
            lo = (i == 2) ? 40 : (i ? 7 : 1);
            for (k = 0; k < 700 * u && reset_req !== 1'b1; k++)
                @(posedge sys_clk);
            check("ovf_time", 1, k >= 400 * lo && k < 700 * u);
            axr(8'h10, rd, rs);
            check("ovf_status", 1, rd[0]);
            check("irq_masked", 0, irq);
        end
        $display("test overflow done");
        test_done();
    end
endmodule // window_watchdog_timer_test
